// ===== logic/pdm_pkg.sv
// Purpose: Shared constants and types of the power-down mode controller.
// Assumes: Register port with byte addresses on a 4-bit address and 16-bit data.
// Notes:   Pin order in the synchronised vector is fixed by the PIN_ indices.
package pdm_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  localparam logic [3:0] OFF_STANDBY_CTL  = 4'h0;
  localparam logic [3:0] OFF_HALT_ONE     = 4'h4;
  localparam logic [3:0] OFF_HALT_TWO     = 4'h8;
  localparam logic [3:0] OFF_MODE_STAT    = 4'hc;

  localparam int BIT_SEL     = 7;
  localparam int BIT_FLOAT   = 6;
  localparam int BIT_IRQWAKE = 0;

  localparam logic       RSV_ZERO    = 1'b0;
  localparam logic [3:0] RSV_ONES    = 4'hf;
  localparam logic       RST_SEL     = 1'b0;
  localparam logic       RST_FLOAT   = 1'b0;
  localparam logic       RST_IRQWAKE = 1'b1;

  localparam logic [15:0] RST_HALT_ONE   = 16'h0000;
  localparam logic [15:0] RST_HALT_TWO   = 16'h0000;
  localparam logic [15:0] DEBUG_MASK_TWO = 16'h000c;

  localparam int N_IRQ  = 4;
  localparam int N_PINS = 7;
  localparam int PIN_NMI    = 0;
  localparam int PIN_IRQ0   = 1;
  localparam int PIN_COLD   = 5;
  localparam int PIN_WARM   = 6;
  localparam logic [6:0] PIN_IDLE = 7'h7f;
  localparam int PIN_HWSTBY_IDLE = 1;

  localparam logic [1:0] IRQ_SEL_LEVEL = 2'h0;
  localparam logic [1:0] IRQ_SEL_FALL  = 2'h1;
  localparam logic [1:0] IRQ_SEL_RISE  = 2'h2;
  localparam logic [1:0] IRQ_SEL_BOTH  = 2'h3;

  typedef enum logic [2:0] {
    ST_NORMAL, ST_SLEEP, ST_SW_STBY, ST_OSC_WAIT, ST_HW_STBY, ST_COLD, ST_WARM
  } pdm_state_t;

  typedef enum logic [1:0] {
    CAUSE_POR, CAUSE_MAN, CAUSE_NMI, CAUSE_IRQ
  } pdm_cause_t;

  typedef struct packed {
    logic cpu_stop;
    logic periph_stop;
    logic osc_run;
    logic wdt_clk_only;
    logic chip_clk;
    logic port_float;
    logic func_reset;
    logic cold_reset;
    logic warm_reset;
  } pdm_pwr_t;

  typedef struct packed {
    logic       start;
    pdm_cause_t cause;
  } pdm_exc_t;

endpackage : pdm_pkg

// ===== logic/pdm_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes: All pins share one idle value given at reset.
// Notes:   A level change is accepted only when the second and third stages agree.
`timescale 1ns/1ps
module pdm_pin_sync #(
  parameter int         W    = 7,
  parameter logic [6:0] IDLE = 7'h7f
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] level_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_reg    <= IDLE[W-1:0];
      s2_reg    <= IDLE[W-1:0];
      s3_reg    <= IDLE[W-1:0];
      level_reg <= IDLE[W-1:0];
    end else begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int k = 0; k < W; k++) begin
        if (s2_reg[k] == s3_reg[k]) begin
          level_reg[k] <= s3_reg[k];
        end
      end
    end
  end

  assign o_level = level_reg;

endmodule : pdm_pin_sync

// ===== logic/pdm_wake_detect.sv
// Purpose: Detects the selected NMI and IRQ edges that end software standby.
// Assumes: Inputs are already synchronised levels.
// Notes:   Low-level IRQ selection never wakes the device.
`timescale 1ns/1ps
module pdm_wake_detect
  import pdm_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_arm,
  input  wire logic               i_nmi,
  input  wire logic               i_nmi_edge_select,
  input  wire logic               i_irq_enable,
  input  wire logic [N_IRQ-1:0]   i_irq,
  input  wire logic [2*N_IRQ-1:0] i_irq_edge_sel_b,
  output logic                    o_nmi_hit,
  output logic                    o_irq_hit
);

  logic             nmi_prev_reg;
  logic [N_IRQ-1:0] irq_prev_reg;
  logic [N_IRQ-1:0] irq_edge;

  function automatic logic wants_fall(input logic [1:0] sel);
    wants_fall = (sel == IRQ_SEL_FALL) || (sel == IRQ_SEL_BOTH);
  endfunction : wants_fall

  function automatic logic wants_rise(input logic [1:0] sel);
    wants_rise = (sel == IRQ_SEL_RISE);
  endfunction : wants_rise

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nmi_prev_reg <= 1'b1;
      irq_prev_reg <= '1;
    end else begin
      nmi_prev_reg <= i_nmi;
      irq_prev_reg <= i_irq;
    end
  end

  // Both-edge selection wakes on the falling edge only.
  for (genvar g = 0; g < N_IRQ; g++) begin : g_irq // see R17, R18
    assign irq_edge[g] =
      (wants_fall(i_irq_edge_sel_b[2*g+:2]) && irq_prev_reg[g] && !i_irq[g]) ||
      (wants_rise(i_irq_edge_sel_b[2*g+:2]) && !irq_prev_reg[g] && i_irq[g]);
  end

  assign o_nmi_hit = i_arm && (i_nmi_edge_select ? (!nmi_prev_reg && i_nmi) // see R12
                                                 : (nmi_prev_reg && !i_nmi));
  assign o_irq_hit = i_arm && i_irq_enable && (|irq_edge);

endmodule : pdm_wake_detect

// ===== logic/pdm_power_down_ctl.sv
// Purpose: Power-down mode controller: sleep, software, hardware and module standby.
// Assumes: CPU, watchdog and interrupt controller run on I_MCLK; pins are asynchronous.
// Notes:   Reset, standby and wake pins pass the three-stage synchroniser.
// Function
// R1 - Halt with select clear stops only CPU.
// R2 - Standby select bit 7 picks sleep or standby.
// R3 - Select cannot be set while watchdog runs.
// R4 - Float bit 6 floats ports in standby.
// R5 - Float cannot be set while alternate watchdog runs.
// R6 - Bit 5 reads 0, bits 4-1 read 1.
// R7 - IRQ wake control bit 0 resets to 1.
// R8 - Cold pin or watchdog power-on ends sleep.
// R9 - Warm pin or watchdog manual reset ends sleep.
// R10 - Hardware standby pin low enters hardware standby.
// R11 - Halt with select set stops everything.
// R12 - Selected NMI edge restarts oscillator, watchdog only.
// R13 - Watchdog overflow clocks chip, starts exception.
// R14 - Software sets overflow beyond oscillator settle time.
// R15 - NMI pin levels must suit the edge.
// R16 - Cold pin low in standby clocks chip.
// R17 - Enabled IRQ edge restarts oscillator, watchdog only.
// R18 - IRQ falling or both wake on falling.
// R19 - Software raises IRQ priority above mask.
// R20 - IRQ pin levels must suit the edge.
// R21 - Module halt bits stop their modules.
// R22 - Debug units ignore their halt bits.
// R23 - Hardware standby resets and stops everything.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
module pdm_power_down_ctl
  import pdm_pkg::*;
(
  input  wire logic               I_MCLK,
  input  wire logic               I_RST_N,
  input  wire logic [ADDR_W-1:0]  I_ADDR,
  input  wire logic [DATA_W-1:0]  I_WDATA,
  input  wire logic               I_WR,
  input  wire logic               I_RD,
  output logic      [DATA_W-1:0]  O_RDATA,
  input  wire logic               I_HALT_EXEC,
  input  wire logic               I_WATCHDOG_RUN,
  input  wire logic               I_WATCHDOG_RUN_ALT,
  input  wire logic               I_WATCHDOG_OVF,
  input  wire logic               I_WATCHDOG_POR,
  input  wire logic               I_WATCHDOG_WARM_START_PIN,
  input  wire logic               I_NMI_PIN,
  input  wire logic               I_NMI_EDGE_SELECT,
  input  wire logic [N_IRQ-1:0]   I_IRQ_PIN,
  input  wire logic [2*N_IRQ-1:0] I_IRQ_EDGE_SEL_B,
  input  wire logic               I_COLD_START_PIN_N,
  input  wire logic               I_WARM_START_PIN_N,
  input  wire logic               I_HW_STANDBY_PIN_N,
  output pdm_pwr_t                O_PWR,
  output pdm_exc_t                O_EXC,
  output logic      [31:0]        O_MODULE_HALT
);

  pdm_state_t   state_reg;
  pdm_state_t   state_next;
  pdm_cause_t   wake_cause_reg;
  pdm_pwr_t     pwr_reg;
  pdm_exc_t     exc_reg;
  logic         fire_next;
  pdm_cause_t   cause_next;
  logic         standby_select_reg;
  logic         port_float_select_reg;
  logic         irq_wake_control_reg;
  logic [15:0]  halt_one_reg;
  logic [15:0]  halt_two_reg;
  logic [15:0]  rdata_reg;
  logic [N_PINS-1:0] pin_raw;
  logic [N_PINS-1:0] pin_lvl;
  logic         hw_lvl;
  logic         cold_low;
  logic         warm_low;
  logic         hw_low;
  logic         nmi_hit;
  logic         irq_hit;
  logic         func_reset;
  logic         ctl_wr;

  assign pin_raw = {I_WARM_START_PIN_N, I_COLD_START_PIN_N, I_IRQ_PIN, I_NMI_PIN};

  pdm_pin_sync #(
    .W    (N_PINS),
    .IDLE (PIN_IDLE)
  ) u_pin_sync (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_pin   (pin_raw),
    .o_level (pin_lvl)
  );

  pdm_pin_sync #(
    .W    (1),
    .IDLE (7'h01)
  ) u_hw_sync (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_pin   (I_HW_STANDBY_PIN_N),
    .o_level (hw_lvl)
  );

  assign cold_low = !pin_lvl[PIN_COLD];
  assign warm_low = !pin_lvl[PIN_WARM];
  assign hw_low   = !hw_lvl;

  // Wake enable follows the bit table: a cleared control bit lets IRQ edges wake.
  pdm_wake_detect u_wake (
    .i_clk             (I_MCLK),
    .i_rst_n           (I_RST_N),
    .i_arm             (state_reg == ST_SW_STBY),
    .i_nmi             (pin_lvl[PIN_NMI]),
    .i_nmi_edge_select (I_NMI_EDGE_SELECT),
    .i_irq_enable      (!irq_wake_control_reg),
    .i_irq             (pin_lvl[PIN_IRQ0+:N_IRQ]),
    .i_irq_edge_sel_b  (I_IRQ_EDGE_SEL_B),
    .o_nmi_hit         (nmi_hit),
    .o_irq_hit         (irq_hit)
  );

  function automatic pdm_pwr_t decode_pwr(input pdm_state_t st, input logic flt);
    pdm_pwr_t p;
    p = '0;
    case (st)
      ST_NORMAL: begin
        p.chip_clk = 1'b1;
        p.osc_run  = 1'b1;
      end
      ST_SLEEP: begin
        p.cpu_stop = 1'b1;
        p.chip_clk = 1'b1;
        p.osc_run  = 1'b1;
      end
      ST_SW_STBY: begin
        p.cpu_stop    = 1'b1;
        p.periph_stop = 1'b1;
        p.port_float  = flt;
      end
      ST_OSC_WAIT: begin
        p.cpu_stop     = 1'b1;
        p.periph_stop  = 1'b1;
        p.osc_run      = 1'b1;
        p.wdt_clk_only = 1'b1;
        p.port_float   = flt;
      end
      ST_HW_STBY: begin
        p.cpu_stop    = 1'b1;
        p.periph_stop = 1'b1;
        p.func_reset  = 1'b1;
      end
      ST_COLD: begin
        p.osc_run    = 1'b1;
        p.chip_clk   = 1'b1;
        p.func_reset = 1'b1;
        p.cold_reset = 1'b1;
      end
      ST_WARM: begin
        p.osc_run    = 1'b1;
        p.chip_clk   = 1'b1;
        p.warm_reset = 1'b1;
      end
      default: begin
        p.func_reset = 1'b1;
      end
    endcase
    decode_pwr = p;
  endfunction : decode_pwr

  always_comb begin
    state_next = state_reg;
    fire_next  = 1'b0;
    cause_next = CAUSE_POR;
    if (hw_low) begin
      state_next = ST_HW_STBY;                                   // see R10
    end else if (state_reg == ST_HW_STBY) begin
      state_next = ST_COLD;
    end else if (cold_low || I_WATCHDOG_POR) begin
      state_next = ST_COLD;                                      // see R8, R16
    end else if (state_reg == ST_COLD) begin
      state_next = ST_NORMAL;
      fire_next  = 1'b1;
      cause_next = CAUSE_POR;
    end else if (warm_low || I_WATCHDOG_WARM_START_PIN) begin
      state_next = ST_WARM;                                      // see R9
    end else begin
      case (state_reg)
        ST_NORMAL: begin
          if (I_HALT_EXEC) begin
            state_next = standby_select_reg ? ST_SW_STBY : ST_SLEEP; // see R1, R2, R11
          end
        end
        ST_SW_STBY: begin
          if (nmi_hit || irq_hit) begin
            state_next = ST_OSC_WAIT;                            // see R12, R17, R18
          end
        end
        ST_OSC_WAIT: begin
          if (I_WATCHDOG_OVF) begin
            state_next = ST_NORMAL;                              // see R13
            fire_next  = 1'b1;
            cause_next = wake_cause_reg;
          end
        end
        ST_WARM: begin
          state_next = ST_NORMAL;
          fire_next  = 1'b1;
          cause_next = CAUSE_MAN;
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= ST_COLD;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wake_cause_reg <= CAUSE_NMI;
    end else if (state_reg == ST_SW_STBY && (nmi_hit || irq_hit)) begin
      wake_cause_reg <= nmi_hit ? CAUSE_NMI : CAUSE_IRQ;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pwr_reg <= '{osc_run: 1'b1, chip_clk: 1'b1, func_reset: 1'b1, cold_reset: 1'b1,
                   default: 1'b0};
      exc_reg <= '{start: 1'b0, cause: CAUSE_POR};
    end else begin
      pwr_reg <= decode_pwr(state_next, port_float_select_reg); // see R4, R23
      exc_reg <= '{start: fire_next, cause: cause_next};
    end
  end

  assign func_reset = (state_reg == ST_HW_STBY) || (state_reg == ST_COLD);
  assign ctl_wr     = I_WR && (I_ADDR == OFF_STANDBY_CTL);

  // A set attempt while the watchdog runs leaves the bit as it was.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      standby_select_reg    <= RST_SEL;
      port_float_select_reg <= RST_FLOAT;
      irq_wake_control_reg  <= RST_IRQWAKE;
    end else if (func_reset) begin
      standby_select_reg    <= RST_SEL;
      port_float_select_reg <= RST_FLOAT;
      irq_wake_control_reg  <= RST_IRQWAKE;                      // see R7
    end else if (ctl_wr) begin
      if (!(I_WDATA[BIT_SEL] && I_WATCHDOG_RUN)) begin
        standby_select_reg <= I_WDATA[BIT_SEL];                  // see R3
      end
      if (!(I_WDATA[BIT_FLOAT] && I_WATCHDOG_RUN_ALT)) begin
        port_float_select_reg <= I_WDATA[BIT_FLOAT];             // see R5
      end
      irq_wake_control_reg <= I_WDATA[BIT_IRQWAKE];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      halt_one_reg <= RST_HALT_ONE;
      halt_two_reg <= RST_HALT_TWO;
    end else if (func_reset) begin
      halt_one_reg <= RST_HALT_ONE;
      halt_two_reg <= RST_HALT_TWO;
    end else if (I_WR && I_ADDR == OFF_HALT_ONE) begin
      halt_one_reg <= I_WDATA;                                   // see R21
    end else if (I_WR && I_ADDR == OFF_HALT_TWO) begin
      halt_two_reg <= I_WDATA;
    end
  end

  // Debug units keep running; their bits only store the written value.
  assign O_MODULE_HALT = {halt_two_reg & ~DEBUG_MASK_TWO, halt_one_reg}; // see R21, R22

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_reg <= '0;
    end else if (I_RD) begin
      case (I_ADDR)
        OFF_STANDBY_CTL: rdata_reg <= {8'h00, standby_select_reg, port_float_select_reg,
                                       RSV_ZERO, RSV_ONES, irq_wake_control_reg}; // see R6
        OFF_HALT_ONE:    rdata_reg <= halt_one_reg;
        OFF_HALT_TWO:    rdata_reg <= halt_two_reg;
        OFF_MODE_STAT:   rdata_reg <= {13'h0000, state_reg};
        default:         rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign O_RDATA = rdata_reg;
  assign O_PWR   = pwr_reg;
  assign O_EXC   = exc_reg;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);

  logic quiet;
  assign quiet = !hw_low && !cold_low && !warm_low && !I_WATCHDOG_POR && !I_WATCHDOG_WARM_START_PIN;

  sequence s_wake_edge;
    quiet && state_reg == ST_SW_STBY && (nmi_hit || irq_hit);
  endsequence

  sequence s_overflow;
    quiet && state_reg == ST_OSC_WAIT && I_WATCHDOG_OVF;
  endsequence

  a_sleep_entry: assert property (quiet && state_reg == ST_NORMAL && I_HALT_EXEC && // see R1
    !standby_select_reg |=> state_reg == ST_SLEEP ##1 O_PWR.cpu_stop && !O_PWR.periph_stop)
    else $error("sleep entry wrong");
  a_stby_entry: assert property (quiet && state_reg == ST_NORMAL && I_HALT_EXEC && // see R2, R11
    standby_select_reg |=> state_reg == ST_SW_STBY ##1 O_PWR.periph_stop && !O_PWR.osc_run)
    else $error("standby entry wrong");
  a_select_refused: assert property (!func_reset && ctl_wr && I_WATCHDOG_RUN && // see R3
    I_WDATA[BIT_SEL] && !standby_select_reg |=> !standby_select_reg)
    else $error("select set while watchdog runs");
  a_float_refused: assert property (!func_reset && ctl_wr && I_WATCHDOG_RUN_ALT && // see R5
    I_WDATA[BIT_FLOAT] && !port_float_select_reg |=> !port_float_select_reg)
    else $error("float set while watchdog runs");
  a_float_drive: assert property (state_reg == ST_SW_STBY && quiet |-> // see R4
    O_PWR.port_float == port_float_select_reg) else $error("port float mismatch");
  a_reserved_read: assert property (I_RD && I_ADDR == OFF_STANDBY_CTL |=> // see R6
    O_RDATA[5:1] == 5'h0f) else $error("reserved bits read wrong");
  a_cold_sleep: assert property (state_reg == ST_SLEEP && !hw_low && // see R8
    (cold_low || I_WATCHDOG_POR) |=> state_reg == ST_COLD && O_PWR.cold_reset)
    else $error("cold start did not end sleep");
  a_warm_sleep: assert property (state_reg == ST_SLEEP && !hw_low && !cold_low && // see R9
    !I_WATCHDOG_POR && (warm_low || I_WATCHDOG_WARM_START_PIN) |=> state_reg == ST_WARM)
    else $error("warm start did not end sleep");
  a_hw_entry: assert property (hw_low |=> state_reg == ST_HW_STBY && // see R10, R23
    O_PWR.func_reset && !O_PWR.osc_run) else $error("hardware standby not entered");
  a_wake_osc: assert property (s_wake_edge |=> state_reg == ST_OSC_WAIT ##1 // see R12, R17
    O_PWR.wdt_clk_only && !O_PWR.chip_clk) else $error("wake did not start oscillator");
  a_ovf_exit: assert property (s_overflow |=> O_EXC.start && // see R13
    O_EXC.cause == wake_cause_reg && O_PWR.chip_clk)
    else $error("overflow did not resume chip");
  a_cold_stby: assert property (state_reg == ST_SW_STBY && !hw_low && cold_low |=> // see R16
    O_PWR.chip_clk && O_PWR.osc_run) else $error("cold start did not clock chip");
  a_debug_run: assert property ((O_MODULE_HALT[31:16] & DEBUG_MASK_TWO) == 16'h0000) // see R22
    else $error("debug unit halted");
  a_cold_exit: assert property (quiet && state_reg == ST_COLD |=> // see R8, R16
    O_EXC.start && O_EXC.cause == CAUSE_POR) else $error("cold exit without reset exception");
  a_irq_blocked: assert property (quiet && state_reg == ST_SW_STBY && // see R7
    irq_wake_control_reg && !nmi_hit |=> state_reg == ST_SW_STBY)
    else $error("disabled irq ended standby");

endmodule : pdm_power_down_ctl

// ===== dv/pdm_wdt_model.sv
// Purpose: Watchdog stand-in that times the oscillator settle after a wake edge.
// Assumes: It counts only while the controller clocks the watchdog alone.
// Notes:   One overflow pulse per wake; the period is a parameter.
`timescale 1ns/1ps
module pdm_wdt_model
  import pdm_pkg::*;
#(
  parameter int OVF_CYCLES = 20
) (
  input  wire logic     i_clk,
  input  wire logic     i_rst_n,
  input  wire pdm_pwr_t i_pwr,
  output logic          o_ovf
);
  int cnt_reg;

  // The period is kept longer than any settle time that the bench assumes.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 0;
      o_ovf   <= 1'b0;
    end else begin
      o_ovf <= i_pwr.wdt_clk_only && (cnt_reg == OVF_CYCLES - 1);
      if (!i_pwr.wdt_clk_only) begin
        cnt_reg <= 0;
      end else if (cnt_reg < OVF_CYCLES) begin
        cnt_reg <= cnt_reg + 1;
      end
    end
  end
endmodule : pdm_wdt_model

// ===== dv/tb.sv
// Purpose: Self-checking bench of the power-down mode controller.
// Assumes: Inputs change by non-blocking assignment at the rising clock edge.
// Notes:   Outputs are sampled 1 ns after an edge, once its updates have landed.
`timescale 1ns/1ps
module tb
  import pdm_pkg::*;
();
  logic        mclk, rst_n, wr, rd, halt, wd_run, wd_alt, wd_por, wd_warm_start_pin, ovf;
  logic        nmi, nmi_sel, cold_n, warm_n, hw_n;
  logic [3:0]  addr, irq;
  logic [7:0]  irq_sel;
  logic [15:0] wdata, rdata;
  logic [31:0] mhalt;
  pdm_pwr_t    pwr;
  pdm_exc_t    exc;
  int          num_errors, checks_done;

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end

  pdm_power_down_ctl dut (
    .I_MCLK(mclk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
    .I_RD(rd), .O_RDATA(rdata), .I_HALT_EXEC(halt), .I_WATCHDOG_RUN(wd_run),
    .I_WATCHDOG_RUN_ALT(wd_alt), .I_WATCHDOG_OVF(ovf), .I_WATCHDOG_POR(wd_por),
    .I_WATCHDOG_WARM_START_PIN(wd_warm_start_pin), .I_NMI_PIN(nmi), .I_NMI_EDGE_SELECT(nmi_sel),
    .I_IRQ_PIN(irq), .I_IRQ_EDGE_SEL_B(irq_sel), .I_COLD_START_PIN_N(cold_n),
    .I_WARM_START_PIN_N(warm_n), .I_HW_STANDBY_PIN_N(hw_n), .O_PWR(pwr), .O_EXC(exc),
    .O_MODULE_HALT(mhalt));

  pdm_wdt_model #(.OVF_CYCLES(20)) wdt (.i_clk(mclk), .i_rst_n(rst_n), .i_pwr(pwr),
    .o_ovf(ovf));

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic chk_rd(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, v)
  endtask : chk_rd

  task automatic halt_cpu();
    @(posedge mclk);
    halt <= 1'b1;
    @(posedge mclk);
    halt <= 1'b0;
    #1;
  endtask : halt_cpu

  task automatic wd_pulse(input bit por);
    @(posedge mclk);
    if (por) wd_por <= 1'b1;
    else wd_warm_start_pin <= 1'b1;
    @(posedge mclk);
    wd_por  <= 1'b0;
    wd_warm_start_pin <= 1'b0;
  endtask : wd_pulse

  task automatic wait_exc(input pdm_cause_t c);
    bit found;
    found = 1'b0;
    for (int i = 0; i < 80 && !found; i++) begin
      @(posedge mclk);
      #1;
      if (exc.start === 1'b1) found = 1'b1;
    end
    `CHK(found, 1'b1)
    `CHK(exc.cause, c)
  endtask : wait_exc

  task automatic t_reset();
    wait_exc(CAUSE_POR);
    chk_rd(4'h0, 16'h001f);
    chk_rd(4'h4, 16'h0000);
    chk_rd(4'h2, 16'h0000);
    chk_rd(4'hc, {13'h0, ST_NORMAL});
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    @(posedge mclk);
    wd_run <= 1'b1;
    wr_reg(4'h0, 16'h00de);
    chk_rd(4'h0, 16'h005e);
    @(posedge mclk);
    wd_run <= 1'b0;
    wd_alt <= 1'b1;
    wr_reg(4'h0, 16'h001f);
    wr_reg(4'h0, 16'h00df);
    chk_rd(4'h0, 16'h009f);
    @(posedge mclk);
    wd_alt <= 1'b0;
    $display("test register refusal done");
  endtask : t_regs

  task automatic t_module();
    wr_reg(4'h4, 16'ha5a5);
    wr_reg(4'h8, 16'hffff);
    tick(1);
    `CHK(mhalt, {16'hffff & ~DEBUG_MASK_TWO, 16'ha5a5})
    chk_rd(4'h8, 16'hffff);
    wr_reg(4'h8, 16'h0000);
    tick(1);
    `CHK(mhalt, 32'h0000a5a5)
    $display("test module halt done");
  endtask : t_module

  task automatic t_sleep();
    wr_reg(4'h0, 16'h001f);
    halt_cpu();
    `CHK(pwr.cpu_stop, 1'b1)
    `CHK(pwr.periph_stop, 1'b0)
    chk_rd(4'hc, {13'h0, ST_SLEEP});
    @(posedge mclk);
    warm_n <= 1'b0;
    tick(6);
    `CHK(pwr.warm_reset, 1'b1)
    @(posedge mclk);
    warm_n <= 1'b1;
    wait_exc(CAUSE_MAN);
    halt_cpu();
    wd_pulse(1'b0);
    wait_exc(CAUSE_MAN);
    halt_cpu();
    wd_pulse(1'b1);
    wait_exc(CAUSE_POR);
    wr_reg(4'h4, 16'h1234);
    halt_cpu();
    @(posedge mclk);
    hw_n <= 1'b0;
    tick(6);
    `CHK(pwr.func_reset, 1'b1)
    `CHK(mhalt, 32'h0)
    @(posedge mclk);
    hw_n <= 1'b1;
    wait_exc(CAUSE_POR);
    chk_rd(4'h4, 16'h0000);
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_nmi();
    wr_reg(4'h0, 16'h00df);
    halt_cpu();
    `CHK(pwr.periph_stop, 1'b1)
    `CHK(pwr.osc_run, 1'b0)
    `CHK(pwr.port_float, 1'b1)
    @(posedge mclk);
    nmi <= 1'b0;
    tick(8);
    `CHK(pwr.wdt_clk_only, 1'b1)
    `CHK(pwr.chip_clk, 1'b0)
    wait_exc(CAUSE_NMI);
    `CHK(pwr.chip_clk, 1'b1)
    @(posedge mclk);
    nmi_sel <= 1'b1;
    wr_reg(4'h0, 16'h009f);
    halt_cpu();
    `CHK(pwr.port_float, 1'b0)
    @(posedge mclk);
    nmi <= 1'b1;
    wait_exc(CAUSE_NMI);
    $display("test nmi wake done");
  endtask : t_nmi

  task automatic t_cold();
    halt_cpu();
    @(posedge mclk);
    cold_n <= 1'b0;
    tick(6);
    `CHK(pwr.chip_clk, 1'b1)
    `CHK(pwr.cold_reset, 1'b1)
    @(posedge mclk);
    cold_n <= 1'b1;
    wait_exc(CAUSE_POR);
    $display("test cold wake done");
  endtask : t_cold

  task automatic t_irq();
    logic [1:0] sel[3] = '{IRQ_SEL_FALL, IRQ_SEL_BOTH, IRQ_SEL_RISE};
    logic       lvl;
    @(posedge mclk);
    nmi_sel <= 1'b0;
    wr_reg(4'h0, 16'h009f);
    halt_cpu();
    @(posedge mclk);
    irq[0] <= 1'b0;
    tick(40);
    `CHK(pwr.wdt_clk_only, 1'b0)
    @(posedge mclk);
    nmi <= 1'b0;
    wait_exc(CAUSE_NMI);
    for (int k = 0; k < 3; k++) begin
      lvl = (sel[k] != IRQ_SEL_RISE);
      @(posedge mclk);
      irq_sel <= {6'h0, sel[k]};
      irq[0]  <= lvl;
      wr_reg(4'h0, 16'h009e);
      tick(6);
      halt_cpu();
      @(posedge mclk);
      irq[0] <= ~lvl;
      wait_exc(CAUSE_IRQ);
    end
    $display("test irq wake done");
  endtask : t_irq

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #200us;
    num_errors++;
    test_done();
  end

  initial begin
    {rst_n, wr, rd, halt, wd_run, wd_alt, wd_por, wd_warm_start_pin, nmi_sel} = '0;
    {nmi, cold_n, warm_n, hw_n} = 4'hf;
    addr    = 4'h0;
    wdata   = 16'h0000;
    irq     = 4'hf;
    irq_sel = 8'h55;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_module();
    t_sleep();
    t_nmi();
    t_cold();
    t_irq();
    test_done();
  end
endmodule : tb
